// File: bench/snp_host_model.sv
// Purpose: host side that issues decoded register commands to the status bank
// Assumes: one command at a time, latch set one edge ahead when asked
// Notes: released command lines are inverted so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module snp_host_model (
   input wire logic clk,
   output logic wel_set,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_addr,
   output logic [7:0] cmd_data,
   output logic [7:0] cmd_data2
);
   initial begin
      wel_set = 1'b0;
      cmd_valid = 1'b0;
      {cmd_code, cmd_addr, cmd_data, cmd_data2} = 32'h0;
   end
   task automatic latch();
      @(posedge clk);
      #1 wel_set = 1'b1;
      @(posedge clk);
      #1 wel_set = 1'b0;
   endtask
   task automatic send(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] d2, input logic w);
      if (w) begin
         latch();
      end else begin
         @(posedge clk);
         #1;
      end
      cmd_valid = 1'b1;
      {cmd_code, cmd_addr, cmd_data, cmd_data2} = {c, a, d, d2};
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      {cmd_code, cmd_addr, cmd_data, cmd_data2} = ~{c, a, d, d2};
   endtask
endmodule // snp_host_model
`default_nettype wire

// File: bench/snp_status_bank_properties.sv
// Purpose: port-level checks of the persistent status bank
// Assumes: mirrors lag their cells by one cycle
// Notes: written against the top ports only
`timescale 1ns/100ps
`default_nettype none
module snp_status_bank_properties (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic WP_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic ARRAY_OP_REQ,
   input wire logic ARRAY_OP_IN_AREA,
   input wire logic [7:0] STATUS_ONE_LIVE,
   input wire logic [7:0] STATUS_ONE_PERSISTENT,
   input wire logic [7:0] CONFIG_ONE_PERSISTENT,
   input wire logic [2:0] ACTIVE_BLOCK_PROTECT,
   input wire logic ARRAY_OP_GRANT,
   input wire logic WHOLE_ERASE_GRANT,
   input wire logic WRITE_IGNORED
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   // pin held three edges covers the two-flop sync lag
   sequence s_pin_low;
      !WP_N [*3];
   endsequence
   sequence s_locked_write;
      CMD_VALID && CMD_CODE == snp_pkg::CMD_WRITE_REGISTERS && STATUS_ONE_PERSISTENT[7];
   endsequence
   a_hw_lock_write: assert property (s_pin_low ##0 s_locked_write |=> WRITE_IGNORED)
      else $error("locked status write not dropped");
   a_live_copy_hwp: assert property ($changed(STATUS_ONE_PERSISTENT[7]) |-> ##[0:1]
      STATUS_ONE_LIVE[7] == STATUS_ONE_PERSISTENT[7]) else $error("live protect copy lost");
   a_ro_defaults: assert property ((STATUS_ONE_PERSISTENT & ~snp_pkg::STATUS_WR_MASK) == 8'h00)
      else $error("read-only default bits changed");
   a_erase_clear_bp: assert property (WHOLE_ERASE_GRANT |-> ACTIVE_BLOCK_PROTECT == 3'h0
      && $past(CMD_VALID) && $past(CMD_CODE) == snp_pkg::CMD_WHOLE_ERASE) else $error("bad erase grant");
   a_area_refused: assert property (ARRAY_OP_REQ && ARRAY_OP_IN_AREA && ACTIVE_BLOCK_PROTECT != 3'h0
      |=> !ARRAY_OP_GRANT) else $error("protected area op granted");
   a_grant_cause: assert property (ARRAY_OP_GRANT |-> $past(ARRAY_OP_REQ))
      else $error("grant without request");
   a_source_locks_bp: assert property (CONFIG_ONE_PERSISTENT[3] |=>
      STATUS_ONE_PERSISTENT[4:2] == snp_pkg::BP_ALL_ONES) else $error("persistent bp not locked");
   a_ignored_cause: assert property (WRITE_IGNORED |-> $past(CMD_VALID) &&
      ($past(CMD_CODE) == 8'h01 || $past(CMD_CODE) == 8'h71)) else $error("stray ignore pulse");
endmodule // snp_status_bank_properties
`default_nettype wire

// File: bench/status_reg_nonvolatile_protect_bench.sv
// Purpose: self-checking bench of the persistent status bank
// Assumes: host model drives commands, bench drives pin, ops and resets
// Notes: block-bit source switch is sticky, so it runs last
`timescale 1ns/100ps
`default_nettype none
module status_reg_nonvolatile_protect_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic soft_reset = 1'b0;
   logic wp_n = 1'b1;
   logic wel_clear = 1'b0;
   logic op_req = 1'b0;
   logic op_in_area = 1'b0;
   logic wel_set, cmd_valid, read_valid, op_grant, op_refuse, erase_grant, write_ignored;
   logic [7:0] cmd_code, cmd_addr, cmd_data, cmd_data2, read_data, st_live, st_nv, cfg_nv, d;
   logic [7:0] exp_st = 8'h00;
   logic [2:0] active_bp;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int seed = 32'h7e64;
   always #20 clk = ~clk;
   snp_host_model u_snp_host_model (.clk(clk), .wel_set(wel_set), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_data2(cmd_data2));
   snp_status_bank u_snp_status_bank (.CORE_CLK(clk), .RESETN(rst_n), .SOFT_RESET(soft_reset),
      .WP_N(wp_n), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_ADDR(cmd_addr),
      .CMD_DATA(cmd_data), .CMD_DATA2(cmd_data2), .WEL_SET(wel_set), .WEL_CLEAR(wel_clear),
      .ARRAY_OP_REQ(op_req), .ARRAY_OP_IN_AREA(op_in_area), .READ_DATA(read_data),
      .READ_VALID(read_valid), .STATUS_ONE_LIVE(st_live), .STATUS_ONE_PERSISTENT(st_nv),
      .CONFIG_ONE_PERSISTENT(cfg_nv), .ACTIVE_BLOCK_PROTECT(active_bp),
      .ARRAY_OP_GRANT(op_grant), .ARRAY_OP_REFUSE(op_refuse),
      .WHOLE_ERASE_GRANT(erase_grant), .WRITE_IGNORED(write_ignored));
   function automatic logic [7:0] merge_st(input logic [7:0] old, input logic [7:0] wr);
      return (old & ~snp_pkg::STATUS_WR_MASK) | (wr & snp_pkg::STATUS_WR_MASK);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      n_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] v, input logic w);
      u_snp_host_model.send(c, a, v, 8'h00, w);
   endtask
   task automatic stop_test();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(st_nv, snp_pkg::STATUS_PERSIST_RESET);
      check(st_live, 8'h00);
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'hff : 8'($random(seed));
         u_snp_host_model.send(8'h01, 8'h00, d, 8'($random(seed)) & 8'hf7, 1'b1);
         exp_st = merge_st(exp_st, d);
         settle();
         check(st_nv, exp_st);
         check(st_live[4:2], exp_st[4:2]);
         check(active_bp, exp_st[4:2]);
         check(st_live[7], exp_st[7]);
      end
      wr(8'h01, 8'h00, 8'h84, 1'b1);
      exp_st = 8'h84;
      u_snp_host_model.latch();
      wel_clear = 1'b1;
      @(posedge clk);
      #1 wel_clear = 1'b0;
      wr(8'h01, 8'h00, 8'h9c, 1'b0);
      check(write_ignored, 8'h01);
      wr(snp_pkg::CMD_WHOLE_ERASE, 8'h00, 8'h00, 1'b1);
      check(erase_grant, 8'h00);
      for (int a = 0; a < 2; a++) begin
         u_snp_host_model.latch();
         op_req = 1'b1;
         op_in_area = a[0];
         @(posedge clk);
         #1 op_req = 1'b0;
         check(op_refuse, 8'(a));
         check(op_grant, 8'(1 - a));
      end
      wp_n = 1'b0;
      settle();
      wr(8'h01, 8'h00, 8'h00, 1'b1);
      check(write_ignored, 8'h01);
      wr(8'h71, snp_pkg::ADDR_CONFIG_ONE_PERSISTENT, 8'h08, 1'b1);
      check(write_ignored, 8'h01);
      wr(8'h71, snp_pkg::ADDR_OTHER_REG, 8'h5a, 1'b1);
      check(write_ignored, 8'h00);
      settle();
      check(st_nv, exp_st);
      wp_n = 1'b1;
      settle();
      wr(8'h01, 8'h00, 8'h00, 1'b1);
      check(write_ignored, 8'h00);
      exp_st = 8'h00;
      settle();
      check(st_nv, exp_st);
      wr(snp_pkg::CMD_WHOLE_ERASE, 8'h00, 8'h00, 1'b1);
      check(erase_grant, 8'h01);
      wp_n = 1'b0;
      settle();
      wr(8'h01, 8'h00, 8'h1c, 1'b1);
      check(write_ignored, 8'h00);
      exp_st = 8'h1c;
      wp_n = 1'b1;
      settle();
      check(st_nv, exp_st);
      wr(snp_pkg::CMD_READ_ANY, snp_pkg::ADDR_STATUS_ONE_PERSISTENT, 8'h00, 1'b0);
      check({read_valid, 7'h00}, 8'h80);
      check(read_data, exp_st);
      wr(8'h71, snp_pkg::ADDR_STATUS_ONE_PERSISTENT, 8'h63, 1'b1);
      exp_st = merge_st(exp_st, 8'h63);
      settle();
      check(st_nv, exp_st);
      wr(8'h71, snp_pkg::ADDR_CONFIG_ONE_PERSISTENT, 8'h08, 1'b1);
      settle();
      check(cfg_nv[3], 8'h01);
      check(st_nv[4:2], snp_pkg::BP_ALL_ONES);
      exp_st[4:2] = snp_pkg::BP_ALL_ONES;
      u_snp_host_model.send(8'h01, 8'h00, 8'h08, 8'h08, 1'b1);
      settle();
      check(st_nv, exp_st);
      check(st_live[4:2], 3'h2);
      check(active_bp, 3'h2);
      soft_reset = 1'b1;
      @(posedge clk);
      #1 soft_reset = 1'b0;
      settle();
      check(st_live[4:2], 3'h7);
      check(active_bp, 3'h7);
      wr(snp_pkg::CMD_READ_ANY, snp_pkg::ADDR_CONFIG_ONE_LIVE, 8'h00, 1'b0);
      check(read_data, 8'h08);
      stop_test();
   end
endmodule // status_reg_nonvolatile_protect_bench
bind snp_status_bank snp_status_bank_properties u_snp_status_bank_properties (
   .CORE_CLK(CORE_CLK), .RESETN(RESETN), .WP_N(WP_N), .CMD_VALID(CMD_VALID),
   .CMD_CODE(CMD_CODE), .ARRAY_OP_REQ(ARRAY_OP_REQ), .ARRAY_OP_IN_AREA(ARRAY_OP_IN_AREA),
   .STATUS_ONE_LIVE(STATUS_ONE_LIVE), .STATUS_ONE_PERSISTENT(STATUS_ONE_PERSISTENT),
   .CONFIG_ONE_PERSISTENT(CONFIG_ONE_PERSISTENT), .ACTIVE_BLOCK_PROTECT(ACTIVE_BLOCK_PROTECT),
   .ARRAY_OP_GRANT(ARRAY_OP_GRANT), .WHOLE_ERASE_GRANT(WHOLE_ERASE_GRANT),
   .WRITE_IGNORED(WRITE_IGNORED));
`default_nettype wire

// File: core/snp_pkg.sv
// Purpose: constants for the persistent status-one register bank
// Assumes: command codes arrive already decoded from the serial framing
// Notes: register indices are the read-any/write-any addresses of this bank
package snp_pkg;
   // command codes
   localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01;
   localparam logic [7:0] CMD_WRITE_ANY = 8'h71;
   localparam logic [7:0] CMD_READ_ANY = 8'h65;
   localparam logic [7:0] CMD_WHOLE_ERASE = 8'h60;
   // register addresses for the any-register commands
   localparam logic [7:0] ADDR_STATUS_ONE_PERSISTENT = 8'h00;
   localparam logic [7:0] ADDR_CONFIG_ONE_PERSISTENT = 8'h02;
   localparam logic [7:0] ADDR_STATUS_ONE_LIVE = 8'h80;
   localparam logic [7:0] ADDR_CONFIG_ONE_LIVE = 8'h82;
   localparam logic [7:0] ADDR_OTHER_REG = 8'h04;
   // status-one field positions, plus the config-one block-source select bit
   localparam int HWP_BIT = 7;
   localparam int PERR_BIT = 6;
   localparam int EERR_BIT = 5;
   localparam int BP_HI = 4;
   localparam int BP_LO = 2;
   localparam int WEL_BIT = 1;
   localparam int WIP_BIT = 0;
   localparam int BPSRC_BIT = 3;
   // writable mask of the persistent status register
   localparam logic [7:0] STATUS_WR_MASK = 8'h9c;
   // shipped defaults
   localparam logic [7:0] STATUS_PERSIST_RESET = 8'h00;
   localparam logic [7:0] CONFIG_PERSIST_RESET = 8'h00;
   localparam logic [7:0] OTHER_RESET = 8'h00;
   localparam logic [2:0] BP_ALL_ONES = 3'h7;
   localparam logic [2:0] BP_NONE = 3'h0;
endpackage

// File: core/snp_status_bank.sv
// Purpose: persistent status-one register with live copy, hardware protect and block protect
// Assumes: one-cycle command strobe with decoded opcode, address and data
// Notes: persistent cells are modelled as flip-flops; no program time is modelled
`timescale 1ns/100ps
`default_nettype none

// Function
// [R1] protect enable set and pin low: status/config writes ignored.
// [R2] protect pin high: status and config writes are accepted.
// [R3] protect enable clear: pin level is ignored, writes allowed.
// [R4] protect pin never blocks writes to other registers.
// [R5] live protect copy always follows persistent protect enable.
// [R6] program-error default seeds live flag, not user writable.
// [R7] erase-error default seeds live flag, not user writable.
// [R8] source select 0: persistent block bits govern; write sets both copies. A write to the live status address sets only the live copy.
// [R9] source select 1: live block bits govern; write leaves persistent.
// [R10] any active block bit set: program/erase in area refused.
// [R11] whole-array erase runs only with all active block bits zero.
// [R12] switching source to live: persistent block bits become ones, locked.
// [R13] write-latch default seeds live latch; not user writable.
// [R14] busy default seeds live busy flag; not user writable.
// [R15] reset loads live copies from persistent copies.
// [R16] write, program and erase ignored unless write latch is set.
// [R17] writes to read-only default bits leave them, others update.
module snp_status_bank (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic SOFT_RESET,
   input wire logic WP_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic [7:0] CMD_ADDR,
   input wire logic [7:0] CMD_DATA,
   input wire logic [7:0] CMD_DATA2,
   input wire logic WEL_SET,
   input wire logic WEL_CLEAR,
   input wire logic ARRAY_OP_REQ,
   input wire logic ARRAY_OP_IN_AREA,
   output logic [7:0] READ_DATA,
   output logic READ_VALID,
   output logic [7:0] STATUS_ONE_LIVE,
   output logic [7:0] STATUS_ONE_PERSISTENT,
   output logic [7:0] CONFIG_ONE_PERSISTENT,
   output logic [2:0] ACTIVE_BLOCK_PROTECT,
   output logic ARRAY_OP_GRANT,
   output logic ARRAY_OP_REFUSE,
   output logic WHOLE_ERASE_GRANT,
   output logic WRITE_IGNORED
);

   // ***************************************************
   // synchronisers
   // ***************************************************
   logic wp_meta_ff;
   logic wp_sync_ff;

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         wp_meta_ff <= 1'b1;
         wp_sync_ff <= 1'b1;
      end else begin
         wp_meta_ff <= WP_N;
         wp_sync_ff <= wp_meta_ff;
      end
   end

   // ***************************************************
   // storage
   // ***************************************************
   logic [7:0] status_persist_ff;
   logic [7:0] config_persist_ff;
   logic [7:0] config_live_ff;
   logic [7:0] other_ff;
   logic [2:0] bp_live_ff;
   logic perr_live_ff;
   logic eerr_live_ff;
   logic wel_live_ff;
   logic wip_live_ff;

   // command decode shared by several processes
   function automatic logic is_write(input logic [7:0] code);
      is_write = (code == snp_pkg::CMD_WRITE_REGISTERS) || (code == snp_pkg::CMD_WRITE_ANY);
   endfunction

   function automatic logic hits_protected(input logic [7:0] code, input logic [7:0] addr);
      hits_protected = (code == snp_pkg::CMD_WRITE_REGISTERS) ||
                       (addr == snp_pkg::ADDR_STATUS_ONE_PERSISTENT) ||
                       (addr == snp_pkg::ADDR_STATUS_ONE_LIVE) ||
                       (addr == snp_pkg::ADDR_CONFIG_ONE_PERSISTENT) ||
                       (addr == snp_pkg::ADDR_CONFIG_ONE_LIVE);
   endfunction

   logic hw_locked;
   logic wr_cmd;
   logic wr_accept;
   logic wr_status;
   logic wr_config;
   logic [7:0] st_data;
   logic bp_src_live;
   logic [2:0] bp_active;
   logic src_switch;

   always_comb begin
      hw_locked = status_persist_ff[snp_pkg::HWP_BIT] && !wp_sync_ff; // [R1] [R3]
      wr_cmd = CMD_VALID && is_write(CMD_CODE) && wel_live_ff; // [R16]
      // lock applies only to status/config targets
      wr_accept = wr_cmd && !(hw_locked && hits_protected(CMD_CODE, CMD_ADDR)); // [R2] [R4]
      wr_status = wr_accept && ((CMD_CODE == snp_pkg::CMD_WRITE_REGISTERS) ||
                  (CMD_ADDR == snp_pkg::ADDR_STATUS_ONE_PERSISTENT) ||
                  (CMD_ADDR == snp_pkg::ADDR_STATUS_ONE_LIVE));
      wr_config = wr_accept && ((CMD_CODE == snp_pkg::CMD_WRITE_REGISTERS) ||
                  (CMD_ADDR == snp_pkg::ADDR_CONFIG_ONE_PERSISTENT) ||
                  (CMD_ADDR == snp_pkg::ADDR_CONFIG_ONE_LIVE));
      st_data = CMD_DATA;
      bp_src_live = config_persist_ff[snp_pkg::BPSRC_BIT];
      bp_active = bp_src_live ? bp_live_ff : status_persist_ff[snp_pkg::BP_HI:snp_pkg::BP_LO];
      // one-way switch, source bit cannot return to zero
      src_switch = wr_config && !bp_src_live &&
                   ((CMD_CODE == snp_pkg::CMD_WRITE_REGISTERS) ?
                    CMD_DATA2[snp_pkg::BPSRC_BIT] :
                    ((CMD_ADDR == snp_pkg::ADDR_CONFIG_ONE_PERSISTENT) &&
                     CMD_DATA[snp_pkg::BPSRC_BIT]));
   end

   // ***************************************************
   // persistent status-one
   // ***************************************************
   logic [7:0] nxt_status_persist;

   always_comb begin
      nxt_status_persist = status_persist_ff;
      if (wr_status && (CMD_ADDR != snp_pkg::ADDR_STATUS_ONE_LIVE ||
                        CMD_CODE == snp_pkg::CMD_WRITE_REGISTERS)) begin
         // defaults keep their value whatever the data says
         nxt_status_persist = (status_persist_ff & ~snp_pkg::STATUS_WR_MASK) |
                              (st_data & snp_pkg::STATUS_WR_MASK); // [R6] [R7] [R13] [R14] [R17]
         if (bp_src_live) begin
            nxt_status_persist[snp_pkg::BP_HI:snp_pkg::BP_LO] =
               status_persist_ff[snp_pkg::BP_HI:snp_pkg::BP_LO]; // [R9] [R12]
         end
      end
      if (src_switch) begin
         nxt_status_persist[snp_pkg::BP_HI:snp_pkg::BP_LO] = snp_pkg::BP_ALL_ONES; // [R12]
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         status_persist_ff <= snp_pkg::STATUS_PERSIST_RESET;
      end else begin
         status_persist_ff <= nxt_status_persist;
      end
   end

   // ***************************************************
   // persistent and live config-one, other register
   // ***************************************************
   logic [7:0] cfg_wdata;
   // live copies reload from persistent at the first edge after reset
   logic reload_ff;

   always_comb begin
      cfg_wdata = (CMD_CODE == snp_pkg::CMD_WRITE_REGISTERS) ? CMD_DATA2 : CMD_DATA;
      if (bp_src_live) begin
         cfg_wdata[snp_pkg::BPSRC_BIT] = 1'b1; // [R12]
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         config_persist_ff <= snp_pkg::CONFIG_PERSIST_RESET;
      end else if (wr_config && CMD_ADDR != snp_pkg::ADDR_CONFIG_ONE_LIVE) begin
         config_persist_ff <= cfg_wdata;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         config_live_ff <= snp_pkg::CONFIG_PERSIST_RESET;
      end else if (reload_ff) begin
         config_live_ff <= config_persist_ff; // [R15]
      end else if (wr_config) begin
         config_live_ff <= cfg_wdata;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         other_ff <= snp_pkg::OTHER_RESET;
      end else if (wr_cmd && CMD_CODE == snp_pkg::CMD_WRITE_ANY &&
                   CMD_ADDR == snp_pkg::ADDR_OTHER_REG) begin
         other_ff <= CMD_DATA; // [R4]
      end
   end

   // ***************************************************
   // live status-one
   // ***************************************************
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         reload_ff <= 1'b1;
      end else begin
         reload_ff <= SOFT_RESET;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         bp_live_ff <= snp_pkg::BP_NONE;
         perr_live_ff <= 1'b0;
         eerr_live_ff <= 1'b0;
         wip_live_ff <= 1'b0;
      end else if (reload_ff) begin
         bp_live_ff <= status_persist_ff[snp_pkg::BP_HI:snp_pkg::BP_LO]; // [R15]
         perr_live_ff <= status_persist_ff[snp_pkg::PERR_BIT]; // [R6]
         eerr_live_ff <= status_persist_ff[snp_pkg::EERR_BIT]; // [R7]
         wip_live_ff <= status_persist_ff[snp_pkg::WIP_BIT]; // [R14]
      end else if (wr_status) begin
         bp_live_ff <= st_data[snp_pkg::BP_HI:snp_pkg::BP_LO]; // [R8] [R9]
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         wel_live_ff <= 1'b0;
      end else if (reload_ff) begin
         wel_live_ff <= status_persist_ff[snp_pkg::WEL_BIT]; // [R13]
      end else if (WEL_SET) begin
         wel_live_ff <= 1'b1;
      end else if (WEL_CLEAR || wr_accept) begin
         // latch drops after a completed write
         wel_live_ff <= 1'b0;
      end
   end

   // ***************************************************
   // protection decisions and read path
   // ***************************************************
   logic [7:0] live_view;
   logic [7:0] rd_mux;

   always_comb begin
      live_view = {status_persist_ff[snp_pkg::HWP_BIT], perr_live_ff, eerr_live_ff,
                   bp_live_ff, wel_live_ff, wip_live_ff}; // [R5]
      case (CMD_ADDR)
         snp_pkg::ADDR_STATUS_ONE_PERSISTENT: rd_mux = status_persist_ff;
         snp_pkg::ADDR_STATUS_ONE_LIVE: rd_mux = live_view;
         snp_pkg::ADDR_CONFIG_ONE_PERSISTENT: rd_mux = config_persist_ff;
         snp_pkg::ADDR_CONFIG_ONE_LIVE: rd_mux = config_live_ff;
         snp_pkg::ADDR_OTHER_REG: rd_mux = other_ff;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         READ_DATA <= 8'h00;
         READ_VALID <= 1'b0;
      end else begin
         READ_VALID <= CMD_VALID && CMD_CODE == snp_pkg::CMD_READ_ANY;
         READ_DATA <= (CMD_VALID && CMD_CODE == snp_pkg::CMD_READ_ANY) ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         STATUS_ONE_LIVE <= 8'h00;
         STATUS_ONE_PERSISTENT <= snp_pkg::STATUS_PERSIST_RESET;
         CONFIG_ONE_PERSISTENT <= snp_pkg::CONFIG_PERSIST_RESET;
         ACTIVE_BLOCK_PROTECT <= snp_pkg::BP_NONE;
         ARRAY_OP_GRANT <= 1'b0;
         ARRAY_OP_REFUSE <= 1'b0;
         WHOLE_ERASE_GRANT <= 1'b0;
         WRITE_IGNORED <= 1'b0;
      end else begin
         STATUS_ONE_LIVE <= live_view;
         STATUS_ONE_PERSISTENT <= status_persist_ff;
         CONFIG_ONE_PERSISTENT <= config_persist_ff;
         ACTIVE_BLOCK_PROTECT <= bp_active;
         ARRAY_OP_GRANT <= ARRAY_OP_REQ && wel_live_ff &&
                           !((bp_active != snp_pkg::BP_NONE) && ARRAY_OP_IN_AREA); // [R10] [R16]
         ARRAY_OP_REFUSE <= ARRAY_OP_REQ && (!wel_live_ff ||
                            ((bp_active != snp_pkg::BP_NONE) && ARRAY_OP_IN_AREA)); // [R10]
         WHOLE_ERASE_GRANT <= CMD_VALID && CMD_CODE == snp_pkg::CMD_WHOLE_ERASE &&
                              wel_live_ff && bp_active == snp_pkg::BP_NONE; // [R11] [R16]
         WRITE_IGNORED <= CMD_VALID && is_write(CMD_CODE) && !wr_accept; // [R1] [R16]
      end
   end

endmodule // snp_status_bank

`default_nettype wire
